// ===== src/urp_pkg.sv
// shared constants and types of the ring indicator and power-save control block
// assumes a 40 MHz system clock and a 1 ms timing tick
`default_nettype none
package urp_pkg;

    // clock and tick timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // phase lengths in ms, one tick per ms
    localparam int RI_ON_MS    = 1000;
    localparam int RI_OFF_MS   = 4000;
    localparam int WAKE_MS     = 20;
    localparam int CYC_ON_MS   = 20;
    localparam int CYC_OFF_MS  = 2500;
    localparam int TICK_MS_NS  = TICK_PERIOD_NS / 1_000_000;
    localparam logic [11:0] RI_ON_TK   = 12'(RI_ON_MS / TICK_MS_NS);
    localparam logic [11:0] RI_OFF_TK  = 12'(RI_OFF_MS / TICK_MS_NS);
    localparam logic [11:0] WAKE_TK    = 12'(WAKE_MS / TICK_MS_NS);
    localparam logic [11:0] CYC_ON_TK  = 12'(CYC_ON_MS / TICK_MS_NS);
    localparam logic [11:0] CYC_OFF_TK = 12'(CYC_OFF_MS / TICK_MS_NS);

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;

    // control fields
    localparam int CFG_LSB  = 0;
    localparam int FLOW_BIT = 2;
    localparam int SMS_BIT  = 3;
    localparam int EXT_BIT  = 4;
    localparam int INIT_BIT = 5;

    // status fields
    localparam int RI_BIT   = 0;
    localparam int UEN_BIT  = 1;
    localparam int LP_BIT   = 2;
    localparam int WAKE_BIT = 3;
    localparam int ERR_BIT  = 4;
    localparam int RTS_BIT  = 5;
    localparam int DTR_BIT  = 6;

    typedef enum logic [1:0] {RI_IDLE, RI_CALL_ON, RI_CALL_OFF, RI_PULSE} urp_ri_st_t;
    typedef enum logic [1:0] {PS_OFF, PS_CYCLIC, PS_RTS, PS_DTR} urp_ps_cfg_t;

    typedef struct packed {
        logic [15:0] tickCnt;
        urp_ri_st_t  riSt;
        logic [11:0] riCnt;
        logic        uartEn;
        logic        waking;
        logic        lowPwr;
        logic [11:0] psCnt;
        urp_ps_cfg_t psCfg;
        logic        flowOn;
        logic        smsRiEn;
        logic        extRiEn;
        logic        cfgErr;
        logic        wrPend;
        logic [7:0]  wrAddr;
        logic [31:0] rdata;
    } urp_state_t;

    // after reset: power save off, flow control on, indicator and uart idle/enabled
    localparam urp_state_t RST_STATE = '{
        tickCnt: 16'h0000, riSt: RI_IDLE, riCnt: 12'h000,
        uartEn: 1'b1, waking: 1'b0, lowPwr: 1'b0, psCnt: 12'h000,
        psCfg: PS_OFF, flowOn: 1'b1, smsRiEn: 1'b0, extRiEn: 1'b0,
        cfgErr: 1'b0, wrPend: 1'b0, wrAddr: 8'h00, rdata: 32'h0000_0000};

endpackage : urp_pkg
`default_nettype wire

// ===== src/urp_sync_if.sv
// carrier between the pin synchroniser and the control block
// raw pin levels in, cleaned levels out
`timescale 1ns/10ps
`default_nettype none
interface urp_sync_if #(parameter int W = 2);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport ctl (output raw, input clean);
    modport syn (input raw, output clean);
endinterface : urp_sync_if
`default_nettype wire

// ===== src/urp_pin_sync.sv
// three-stage synchroniser for asynchronous input pins
// a change is taken once the second and third stages agree; idle level is high
`timescale 1ns/10ps
`default_nettype none
module urp_pin_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // pins
    urp_sync_if.syn   sp
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] clean;
    } urp_sync_st_t;

    urp_sync_st_t st_q;
    urp_sync_st_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = sp.raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // s1 feeds only s2: metastable bits never reach the comparison
        for (int i = 0; i < WIDTH; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.clean[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign sp.clean = st_q.clean;
endmodule : urp_pin_sync
`default_nettype wire

// ===== src/urp_ring_power.sv
// ring indicator and uart power-save control, AHB-Lite register slave
// assumes a uart core beside it that offers received characters and transmit requests
// How it works
// - after init the ring indicator sits inactive (high) until an event
// - pending call toggles indicator: 1 s active, 4 s inactive, stops on answer
// - textual ring messages run independently of indicator timing
// - with sms notify enabled each sms drives indicator active for 1 s
// - each sms restarts the pulse without a gap, stretching it past 1 s
// - call answered inside the first active second drops indicator at once
// - extended notify: each configured event asserts 1 s, restarted by further events
// - power-save config 0 keeps the uart always active; it is the default
// - config 1 cycles the uart between idle and active periods
// - configs 2 and 3 are governed by request-to-send and terminal-ready
// - with power save on, low power only when no activity needs the module
// - flow control on and request-to-send off holds outgoing data until reasserted
// - flow control off transmits without checking host readiness
// - config 1 without flow control: first char dropped, wakes uart after ~20 ms
// - config 2 is refused while flow control is enabled
// - config 2: characters received only while request-to-send is active
// - config 3: characters received only while terminal-ready is active
// - inactive-to-active control input enables uart about 20 ms later
// - clear-to-send low when uart enabled, high when disabled
// - config 1: uart on ~20 ms, then off 2.5 s without traffic
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module urp_ring_power #(
    parameter int TICK_CYC = urp_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // serial control pins, active low
    input  wire logic        rtsPin_n,
    input  wire logic        dtrPin_n,
    output logic             riPin_n,
    output logic             ctsPin_n,
    // notifying events
    input  wire logic        callPending,
    input  wire logic        smsArrival,
    input  wire logic        extEvent,
    // module activity
    input  wire logic        netBusy,
    input  wire logic        ifBusy,
    output logic             lowPower,
    // uart core handshake
    input  wire logic        rxValid,
    output logic             rxAccept,
    output logic             rxDrop,
    input  wire logic        txReq,
    output logic             txGo
);
    urp_pkg::urp_state_t q;
    urp_pkg::urp_state_t d;

    urp_sync_if #(.W(2)) pinIf ();

    logic                tick;
    logic                rtsOn;
    logic                dtrOn;
    logic                ctlOn;
    logic                rxOk;
    logic                traffic;
    logic                pulseEv;
    logic                initReq;
    logic                addrPh;
    logic                riActive;
    urp_pkg::urp_ps_cfg_t newCfg;
    logic                newFlow;
    logic [31:0]         rdMux;

    assign pinIf.raw = {dtrPin_n, rtsPin_n};

    urp_pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .sp      (pinIf)
    );

    assign rtsOn = ~pinIf.clean[0];
    assign dtrOn = ~pinIf.clean[1];

    // handshakes to the uart core
    assign rxOk = q.uartEn
                  && (q.psCfg != urp_pkg::PS_RTS || rtsOn)
                  && (q.psCfg != urp_pkg::PS_DTR || dtrOn);
    assign rxAccept = rxValid && rxOk;
    assign rxDrop   = rxValid && !rxOk;
    // with flow control off nothing is checked, the host must keep up
    assign txGo     = txReq && (!q.flowOn || rtsOn);
    assign traffic  = rxAccept || txGo;
    assign ctlOn    = (q.psCfg == urp_pkg::PS_RTS) ? rtsOn : dtrOn;

    assign riActive = (q.riSt == urp_pkg::RI_CALL_ON) || (q.riSt == urp_pkg::RI_PULSE);

    // zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = q.rdata;
    assign riPin_n   = ~riActive;
    assign ctsPin_n  = ~q.uartEn;
    assign lowPower  = q.lowPwr;
    assign addrPh    = hsel && htrans[1] && hready;

    always_comb begin
        rdMux = 32'h0000_0000;
        case (haddr[7:0])
            urp_pkg::CTRL_OFS: begin
                rdMux[urp_pkg::CFG_LSB +: 2] = q.psCfg;
                rdMux[urp_pkg::FLOW_BIT]     = q.flowOn;
                rdMux[urp_pkg::SMS_BIT]      = q.smsRiEn;
                rdMux[urp_pkg::EXT_BIT]      = q.extRiEn;
            end
            urp_pkg::STAT_OFS: begin
                rdMux[urp_pkg::RI_BIT]   = riActive;
                rdMux[urp_pkg::UEN_BIT]  = q.uartEn;
                rdMux[urp_pkg::LP_BIT]   = q.lowPwr;
                rdMux[urp_pkg::WAKE_BIT] = q.waking;
                rdMux[urp_pkg::ERR_BIT]  = q.cfgErr;
                rdMux[urp_pkg::RTS_BIT]  = rtsOn;
                rdMux[urp_pkg::DTR_BIT]  = dtrOn;
            end
            default: begin
                rdMux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        d       = q;
        initReq = 1'b0;
        newCfg  = urp_pkg::urp_ps_cfg_t'(hwdata[urp_pkg::CFG_LSB +: 2]);
        newFlow = hwdata[urp_pkg::FLOW_BIT];
        pulseEv = (smsArrival && q.smsRiEn) || (extEvent && q.extRiEn);
        tick    = (q.tickCnt == 16'(TICK_CYC - 1));
        d.tickCnt = tick ? 16'h0000 : q.tickCnt + 16'h0001;

        // bus: address phase, then register write in the data phase
        d.wrPend = addrPh && hwrite;
        if (addrPh) begin
            d.wrAddr = haddr[7:0];
        end
        if (addrPh && !hwrite) begin
            d.rdata = rdMux;
        end
        if (q.wrPend) begin
            case (q.wrAddr)
                urp_pkg::CTRL_OFS: begin
                    if (newCfg == urp_pkg::PS_RTS && newFlow) begin
                        d.cfgErr = 1'b1;
                    end else begin
                        d.psCfg  = newCfg;
                        d.flowOn = newFlow;
                    end
                    d.smsRiEn = hwdata[urp_pkg::SMS_BIT];
                    d.extRiEn = hwdata[urp_pkg::EXT_BIT];
                    initReq   = hwdata[urp_pkg::INIT_BIT];
                end
                urp_pkg::STAT_OFS: begin
                    if (hwdata[urp_pkg::ERR_BIT]) begin
                        d.cfgErr = 1'b0;
                    end
                end
                default: begin
                    d.cfgErr = q.cfgErr;
                end
            endcase
        end

        // ring indicator; the textual ring on the data line is not aligned to it
        case (q.riSt)
            urp_pkg::RI_IDLE: begin
                d.riCnt = 12'h000;
                if (callPending) begin
                    d.riSt = urp_pkg::RI_CALL_ON;
                end else if (pulseEv) begin
                    d.riSt = urp_pkg::RI_PULSE;
                end
            end
            urp_pkg::RI_CALL_ON: begin
                if (!callPending) begin
                    d.riSt = urp_pkg::RI_IDLE;
                end else if (tick) begin
                    if (q.riCnt == urp_pkg::RI_ON_TK - 12'h001) begin
                        d.riSt  = urp_pkg::RI_CALL_OFF;
                        d.riCnt = 12'h000;
                    end else begin
                        d.riCnt = q.riCnt + 12'h001;
                    end
                end
            end
            urp_pkg::RI_CALL_OFF: begin
                if (!callPending) begin
                    d.riSt = urp_pkg::RI_IDLE;
                end else if (pulseEv) begin
                    d.riSt  = urp_pkg::RI_PULSE;
                    d.riCnt = 12'h000;
                end else if (tick) begin
                    if (q.riCnt == urp_pkg::RI_OFF_TK - 12'h001) begin
                        d.riSt  = urp_pkg::RI_CALL_ON;
                        d.riCnt = 12'h000;
                    end else begin
                        d.riCnt = q.riCnt + 12'h001;
                    end
                end
            end
            urp_pkg::RI_PULSE: begin
                if (pulseEv) begin
                    d.riCnt = 12'h000;
                end else if (tick) begin
                    if (q.riCnt == urp_pkg::RI_ON_TK - 12'h001) begin
                        d.riSt  = urp_pkg::RI_IDLE;
                        d.riCnt = 12'h000;
                    end else begin
                        d.riCnt = q.riCnt + 12'h001;
                    end
                end
            end
            default: begin
                d.riSt = urp_pkg::RI_IDLE;
            end
        endcase

        // uart power-save control
        case (q.psCfg)
            urp_pkg::PS_OFF: begin
                d.uartEn = 1'b1;
                d.waking = 1'b0;
                d.psCnt  = 12'h000;
            end
            urp_pkg::PS_CYCLIC: begin
                if (q.waking) begin
                    if (tick) begin
                        d.psCnt = q.psCnt + 12'h001;
                        if (q.psCnt == urp_pkg::WAKE_TK - 12'h001) begin
                            d.waking = 1'b0;
                            d.uartEn = 1'b1;
                            d.psCnt  = 12'h000;
                        end
                    end
                end else if (q.uartEn) begin
                    if (traffic) begin
                        d.psCnt = 12'h000;
                    end else if (tick) begin
                        d.psCnt = q.psCnt + 12'h001;
                        if (q.psCnt == urp_pkg::CYC_ON_TK - 12'h001) begin
                            d.uartEn = 1'b0;
                            d.psCnt  = 12'h000;
                        end
                    end
                end else if (rxValid && !q.flowOn) begin
                    d.waking = 1'b1;
                    d.psCnt  = 12'h000;
                end else if (txReq) begin
                    // outgoing data opens the uart early
                    d.uartEn = 1'b1;
                    d.psCnt  = 12'h000;
                end else if (tick) begin
                    d.psCnt = q.psCnt + 12'h001;
                    if (q.psCnt == urp_pkg::CYC_OFF_TK - 12'h001) begin
                        d.uartEn = 1'b1;
                        d.psCnt  = 12'h000;
                    end
                end
            end
            default: begin
                // request-to-send or terminal-ready governs the uart
                if (!ctlOn) begin
                    d.uartEn = 1'b0;
                    d.waking = 1'b0;
                    d.psCnt  = 12'h000;
                end else if (!q.uartEn && !q.waking) begin
                    d.waking = 1'b1;
                    d.psCnt  = 12'h000;
                end else if (q.waking && tick) begin
                    d.psCnt = q.psCnt + 12'h001;
                    if (q.psCnt == urp_pkg::WAKE_TK - 12'h001) begin
                        d.waking = 1'b0;
                        d.uartEn = 1'b1;
                        d.psCnt  = 12'h000;
                    end
                end
            end
        endcase

        // low power needs every activity source quiet
        d.lowPwr = (q.psCfg != urp_pkg::PS_OFF) && !q.uartEn && !q.waking
                   && !netBusy && !ifBusy && !txReq;

        // init clears the tick counter and parks the indicator
        if (initReq) begin
            d.tickCnt = 16'h0000;
            d.riSt    = urp_pkg::RI_IDLE;
            d.riCnt   = 12'h000;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            q <= urp_pkg::RST_STATE;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    AST_RI_INIT: assert property (initReq |=> riPin_n && q.tickCnt == 16'h0000)
        else $error("indicator not parked after init");

    AST_RI_CALL_ON: assert property ((q.riSt == urp_pkg::RI_CALL_ON)
        |-> !riPin_n && q.riCnt < urp_pkg::RI_ON_TK)
        else $error("call on phase wrong");

    AST_RI_CALL_OFF: assert property ((q.riSt == urp_pkg::RI_CALL_OFF && callPending
        && !pulseEv && tick && q.riCnt == urp_pkg::RI_OFF_TK - 12'h001 && !initReq)
        |=> !riPin_n && q.riCnt == 12'h000)
        else $error("off phase did not end in on phase");

    AST_RI_ANSWER: assert property (((q.riSt == urp_pkg::RI_CALL_ON
        || q.riSt == urp_pkg::RI_CALL_OFF) && !callPending) |=> riPin_n)
        else $error("indicator not dropped on answer");

    AST_RI_RETRIG: assert property ((q.riSt == urp_pkg::RI_PULSE && pulseEv && !initReq)
        |=> !riPin_n && q.riCnt == 12'h000)
        else $error("pulse not restarted");

    AST_RI_EXT: assert property ((q.riSt == urp_pkg::RI_IDLE && !callPending && !initReq
        && extEvent && q.extRiEn) |=> q.riSt == urp_pkg::RI_PULSE && !riPin_n)
        else $error("extended event missed");

    AST_CFG0_ON: assert property ((q.psCfg == urp_pkg::PS_OFF) [*2] |-> !ctsPin_n)
        else $error("uart off in config 0");

    AST_RX_GATE: assert property (rxAccept |-> !ctsPin_n
        && (q.psCfg != urp_pkg::PS_RTS || rtsOn)
        && (q.psCfg != urp_pkg::PS_DTR || dtrOn))
        else $error("character taken while gated");

    AST_TX_HOLD: assert property ((q.flowOn && !rtsOn) |-> !txGo)
        else $error("sent while host not ready");

    AST_CFG2_FLOW: assert property (!(q.psCfg == urp_pkg::PS_RTS && q.flowOn))
        else $error("config 2 with flow control");

    AST_WAKE: assert property ((q.psCfg == urp_pkg::PS_DTR && !q.uartEn
        && !q.waking && dtrOn) |=> q.waking ##1 !q.uartEn)
        else $error("wake not started");

    AST_LOWPWR: assert property (lowPower |-> !$past(netBusy) && !$past(ifBusy)
        && $past(q.psCfg) != urp_pkg::PS_OFF)
        else $error("low power while busy");

endmodule : urp_ring_power
`default_nettype wire

// ===== tb/urp_host_model.sv
// host model on the serial port: handshake pins and character offers
// assumes bench controls change just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module urp_host_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // bench control
    input  wire logic rtsOn,
    input  wire logic dtrOn,
    input  wire logic charReq,
    input  wire logic waitCts,
    // device pins
    input  wire logic ctsPin_n,
    output logic      rtsPin_n,
    output logic      dtrPin_n,
    output logic      rxValid
);
    logic pend_q;
    // active low; off level is high as the pull-ups would give
    assign rtsPin_n = ~rtsOn;
    assign dtrPin_n = ~dtrOn;
    // a held character goes out only once clear-to-send shows low
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q  <= 1'b0;
            rxValid <= 1'b0;
        end else if ((pend_q | charReq) & (~waitCts | ~ctsPin_n)) begin
            pend_q  <= 1'b0;
            rxValid <= 1'b1;
        end else begin
            pend_q  <= pend_q | charReq;
            rxValid <= 1'b0;
        end
    end
endmodule : urp_host_model
`default_nettype wire

// ===== tb/tb_urp_ring_power.sv
// self-checking bench of the ring and power-save block, tick shortened to 4 clocks
// assumes the host model on the serial side and a single AHB-Lite master here
`timescale 1ns/10ps
`default_nettype none
module tb_urp_ring_power;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic [1:0]  htrans = 2'h0;
    logic        hreadyout, hresp, riPin_n, ctsPin_n, rtsPin_n, dtrPin_n, rxValid;
    logic        rtsOn = 1'b0, dtrOn = 1'b0, charReq = 1'b0, waitCts = 1'b0;
    logic        callPending = 1'b0, smsArrival = 1'b0, extEvent = 1'b0;
    logic        netBusy = 1'b0, ifBusy = 1'b0, txReq = 1'b0;
    logic        lowPower, rxAccept, rxDrop, txGo;
    logic [15:0] lfsr;
    int          badCount = 0, nTests = 0, n, d;

    always #12.5 clk_sys = ~clk_sys;

    urp_ring_power #(.TICK_CYC(4)) urp_ring_power_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rtsPin_n(rtsPin_n), .dtrPin_n(dtrPin_n), .riPin_n(riPin_n),
        .ctsPin_n(ctsPin_n), .callPending(callPending), .smsArrival(smsArrival),
        .extEvent(extEvent), .netBusy(netBusy), .ifBusy(ifBusy), .lowPower(lowPower),
        .rxValid(rxValid), .rxAccept(rxAccept), .rxDrop(rxDrop), .txReq(txReq), .txGo(txGo));
    urp_host_model urp_host_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .rtsOn(rtsOn),
        .dtrOn(dtrOn), .charReq(charReq), .waitCts(waitCts), .ctsPin_n(ctsPin_n),
        .rtsPin_n(rtsPin_n), .dtrPin_n(dtrPin_n), .rxValid(rxValid));

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    task automatic reportAndStop();
        if (badCount == 0 && nTests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : reportAndStop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : chk1

    // one single transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask : bus

    task automatic at(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : at

    task automatic pulse(input logic ext);
        @(posedge clk_sys);
        smsArrival <= ~ext;
        extEvent   <= ext;
        @(posedge clk_sys);
        smsArrival <= 1'b0;
        extEvent   <= 1'b0;
        #1;
    endtask : pulse

    task automatic sendChar(input logic acc, input logic drop);
        @(posedge clk_sys);
        charReq <= 1'b1;
        @(posedge clk_sys);
        charReq <= 1'b0;
        #1;
        chk1("rxAccept", acc, rxAccept);
        chk1("rxDrop", drop, rxDrop);
        @(posedge clk_sys);
    endtask : sendChar

    task automatic ctsWait(input logic lvl);
        n = 0;
        while (ctsPin_n !== lvl && n < 12000) begin
            at(1);
            n++;
        end
    endtask : ctsWait

    initial begin
        repeat (98000) @(posedge clk_sys);
        badCount++;
        reportAndStop();
    end

    initial begin
        lfsr = 16'hD1E0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        at(1);
        chk1("riPin_n", 1'b1, riPin_n);
        chk1("ctsPin_n", 1'b0, ctsPin_n);
        @(posedge clk_sys);
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h0000_0004, v);
        bus(1'b0, 8'h04, 32'h0);
        chk("status", 32'h0000_0002, v);
        lfsr = nxt(lfsr);
        bus(1'b1, 8'h0C, {lfsr, 16'h0});
        bus(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, v);
        txReq <= 1'b1;
        #1;
        chk1("txGo", 1'b0, txGo);
        @(posedge clk_sys);
        rtsOn <= 1'b1;
        at(6);
        chk1("txGo", 1'b1, txGo);
        chk1("lowPower", 1'b0, lowPower);
        @(posedge clk_sys);
        txReq <= 1'b0;
        pulse(1'b0);
        chk1("riPin_n", 1'b1, riPin_n);
        @(posedge clk_sys);
        bus(1'b1, 8'h00, 32'h0000_000C);
        pulse(1'b0);
        chk1("riPin_n", 1'b0, riPin_n);
        lfsr = nxt(lfsr);
        d = 400 + int'(lfsr % 16'h07D0);
        at(d);
        pulse(1'b0);
        at(4100 - d);
        chk1("riPin_n", 1'b0, riPin_n);
        at(d - 200);
        chk1("riPin_n", 1'b0, riPin_n);
        at(300);
        chk1("riPin_n", 1'b1, riPin_n);
        @(posedge clk_sys);
        bus(1'b1, 8'h00, 32'h0000_0014);
        pulse(1'b1);
        chk1("riPin_n", 1'b0, riPin_n);
        at(2000);
        pulse(1'b1);
        at(3900);
        chk1("riPin_n", 1'b0, riPin_n);
        at(200);
        chk1("riPin_n", 1'b1, riPin_n);
        pulse(1'b1);
        @(posedge clk_sys);
        bus(1'b1, 8'h00, 32'h0000_0034);
        at(2);
        chk1("riPin_n", 1'b1, riPin_n);
        @(posedge clk_sys);
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h0000_0014, v);
        callPending <= 1'b1;
        at(2);
        chk1("riPin_n", 1'b0, riPin_n);
        at(3950);
        chk1("riPin_n", 1'b0, riPin_n);
        at(200);
        chk1("riPin_n", 1'b1, riPin_n);
        at(15700);
        chk1("riPin_n", 1'b1, riPin_n);
        at(300);
        chk1("riPin_n", 1'b0, riPin_n);
        @(posedge clk_sys);
        callPending <= 1'b0;
        at(1);
        chk1("riPin_n", 1'b1, riPin_n);
        @(posedge clk_sys);
        bus(1'b1, 8'h00, 32'h0000_0006);
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h0000_0004, v);
        bus(1'b0, 8'h04, 32'h0);
        chk("cfgErr", 32'h0000_0010, v & 32'h0000_0010);
        bus(1'b1, 8'h04, 32'h0000_0010);
        bus(1'b0, 8'h04, 32'h0);
        chk("cfgErr", 32'h0, v & 32'h0000_0010);
        bus(1'b1, 8'h00, 32'h0000_0002);
        rtsOn <= 1'b0;
        at(8);
        chk1("ctsPin_n", 1'b1, ctsPin_n);
        chk1("lowPower", 1'b1, lowPower);
        @(posedge clk_sys);
        netBusy <= 1'b1;
        txReq   <= 1'b1;
        at(3);
        chk1("lowPower", 1'b0, lowPower);
        chk1("txGo", 1'b1, txGo);
        @(posedge clk_sys);
        netBusy <= 1'b0;
        txReq   <= 1'b0;
        sendChar(1'b0, 1'b1);
        rtsOn <= 1'b1;
        at(40);
        chk1("ctsPin_n", 1'b1, ctsPin_n);
        at(80);
        chk1("ctsPin_n", 1'b0, ctsPin_n);
        sendChar(1'b1, 1'b0);
        bus(1'b1, 8'h00, 32'h0000_0007);
        at(8);
        chk1("ctsPin_n", 1'b1, ctsPin_n);
        sendChar(1'b0, 1'b1);
        dtrOn <= 1'b1;
        at(120);
        sendChar(1'b1, 1'b0);
        rtsOn <= 1'b0;
        txReq <= 1'b1;
        at(6);
        chk1("txGo", 1'b0, txGo);
        @(posedge clk_sys);
        txReq <= 1'b0;
        bus(1'b1, 8'h00, 32'h0000_0001);
        ctsWait(1'b1);
        ctsWait(1'b0);
        chk1("offSpan", 1'b1, n inside {[9980:10010]});
        ctsWait(1'b1);
        chk1("onSpan", 1'b1, n inside {[70:86]});
        sendChar(1'b0, 1'b1);
        ctsWait(1'b0);
        chk1("wakeSpan", 1'b1, n inside {[66:86]});
        @(posedge clk_sys);
        bus(1'b1, 8'h00, 32'h0000_0005);
        waitCts <= 1'b1;
        ctsWait(1'b1);
        sendChar(1'b0, 1'b0);
        n = 0;
        while (rxValid !== 1'b1 && n < 11000) begin
            at(1);
            n++;
        end
        chk1("rxAccept", 1'b1, rxAccept);
        reportAndStop();
    end
endmodule : tb_urp_ring_power
`default_nettype wire
